// ---- rtl/frontend_defines.vh ----
`ifndef FRONTEND_DEFINES_VH
`define FRONTEND_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Addressing and stream widths.
`define INSTR_BYTES 32'h0000_0004
`define CHUNK_BYTES 32
`define CHUNK_LSB 5
`define CHUNK_BITS 256
`define UOP_W 64
`define UOPS_PER_CLK 3
`define RESET_PC 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Storage sizes: 4096 lines of three slots give 12288 micro-operations.
`define TRACE_UOPS 12288
`define TRACE_IDX_W 12
`define BTT_IDX_W 8
`define RAS_DEPTH 16
`define RAS_PTR_W 4

////////////////////////////////////////////////////////////////////////////////
// Instruction word fields.
`define CLS_MSB 31
`define CLS_LSB 29
`define UC_LEN_MSB 28
`define UC_LEN_LSB 26
`define UC_OP_MSB 23
`define UC_OP_LSB 16
`define DISP_MSB 15

////////////////////////////////////////////////////////////////////////////////
// Instruction classes.
`define CLS_PLAIN 3'h0
`define CLS_COND 3'h1
`define CLS_JUMP 3'h2
`define CLS_CALL 3'h3
`define CLS_RET 3'h4
`define CLS_INDIRECT 3'h5
`define CLS_FAR 3'h6
`define CLS_COMPLEX 3'h7

////////////////////////////////////////////////////////////////////////////////
// Delivery source codes and microcode word marker.
`define SRC_NONE 2'h0
`define SRC_TRACE 2'h1
`define SRC_DECODE 2'h2
`define SRC_UCODE 2'h3
`define UC_MARK 8'hEC

`endif

// ---- rtl/line_memory.v ----
// One read and one write port; read data come from a register and show the
// old word when the same address is written in the same cycle.
module line_memory #(
  parameter WIDTH = 64,
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg rd_valid,
  output reg [WIDTH-1:0] rd_data
);

  localparam DEPTH = 1 << ADDR_W;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH-1:0] vld;

  ////////////////////////////////////////////////////////////////////////////
  // Valid bits are flops so that reset empties the store without a sweep.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vld <= {DEPTH{1'b0}};
      rd_valid <= 1'b0;
      rd_data <= {WIDTH{1'b0}};
    end else if (ce) begin
      rd_valid <= vld[rd_addr];
      rd_data <= mem[rd_addr];
      if (wr_en) begin
        vld[wr_addr] <= 1'b1;
      end
    end
  end

  // The array itself carries no reset.
  always @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule

// ---- rtl/instruction_frontend_predictor.v ----
`include "frontend_defines.vh"

module instruction_frontend_predictor #(
  parameter TRACE_IDX_W = `TRACE_IDX_W,
  parameter BTT_IDX_W = `BTT_IDX_W,
  parameter [31:0] RESET_PC = `RESET_PC
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire core_ready,
  output reg [2:0] uop_valid,
  output reg [`UOP_W-1:0] uop_word0,
  output reg [`UOP_W-1:0] uop_word1,
  output reg [`UOP_W-1:0] uop_word2,
  output reg [1:0] uop_source,
  output reg fetch_req,
  output reg [31:0] fetch_addr,
  input wire fetch_valid,
  input wire [`CHUNK_BITS-1:0] fetch_data,
  input wire retire_valid,
  input wire [31:0] retire_pc,
  input wire [31:0] retire_target,
  input wire retire_taken,
  input wire retire_mispredict
);

  localparam TS_TAG_W = 32 - TRACE_IDX_W - 2;
  localparam BT_TAG_W = 32 - BTT_IDX_W - 2;
  localparam SLOTS_W = `UOPS_PER_CLK * `UOP_W;
  localparam LINE_W = TS_TAG_W + 32 + 2 + SLOTS_W;
  localparam BTT_W = BT_TAG_W + 32 + 1;
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_UCODE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  function [TRACE_IDX_W-1:0] ts_index;
    input [31:0] a;
    ts_index = a[TRACE_IDX_W+1:2];
  endfunction

  function [TS_TAG_W-1:0] ts_tag;
    input [31:0] a;
    ts_tag = a[31:TRACE_IDX_W+2];
  endfunction

  function [BTT_IDX_W-1:0] btt_index;
    input [31:0] a;
    btt_index = a[BTT_IDX_W+1:2];
  endfunction

  function [BT_TAG_W-1:0] btt_tag;
    input [31:0] a;
    btt_tag = a[31:BTT_IDX_W+2];
  endfunction

  // Chunk base: the fetcher always asks for whole aligned 32-byte chunks.
  function [31:0] chunk_of;
    input [31:0] a;
    chunk_of = {a[31:`CHUNK_LSB], {`CHUNK_LSB{1'b0}}};
  endfunction

  function [2:0] cnt_mask;
    input [1:0] n;
    case (n)
      2'h1: cnt_mask = 3'h1;
      2'h2: cnt_mask = 3'h3;
      2'h3: cnt_mask = 3'h7;
      default: cnt_mask = 3'h0;
    endcase
  endfunction

  // Microcode ROM: each step of an expansion is a fixed word.
  function [31:0] ucode_rom;
    input [7:0] op;
    input [2:0] step;
    ucode_rom = {`UC_MARK, op, 13'h0000, step};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] state;
  reg [31:0] pc;
  reg buf_valid;
  reg [31:0] buf_base;
  reg [`CHUNK_BITS-1:0] buf_data;
  reg [1:0] bld_cnt;
  reg [31:0] bld_start;
  reg [`UOP_W-1:0] bld_u0;
  reg [`UOP_W-1:0] bld_u1;
  reg [2:0] uc_step;
  reg [2:0] uc_last;
  reg [7:0] uc_op;
  reg [31:0] ras [0:`RAS_DEPTH-1];
  reg [`RAS_PTR_W-1:0] ras_top;
  reg [`RAS_PTR_W:0] ras_cnt;
  integer i;

  wire ts_rd_valid;
  wire [LINE_W-1:0] ts_rd_data;
  wire btt_rd_valid;
  wire [BTT_W-1:0] btt_rd_data;
  wire [TS_TAG_W-1:0] ln_tag = ts_rd_data[LINE_W-1 -: TS_TAG_W];
  wire [31:0] ln_next = ts_rd_data[SLOTS_W+2 +: 32];
  wire [1:0] ln_cnt = ts_rd_data[SLOTS_W +: 2];
  wire [BT_TAG_W-1:0] bt_tag = btt_rd_data[BTT_W-1 -: BT_TAG_W];
  wire [31:0] bt_target = btt_rd_data[32:1];
  wire bt_taken = btt_rd_data[0];

  reg flush, advance, hit, buf_hit, btt_hit, taken, push, pop;
  reg do_deliver, do_close, do_decode, do_complex, do_fetch, uc_done;
  reg [31:0] instr, disp, fall, target, pred_next, redirect, next_pc;
  reg [2:0] cls;
  reg ts_we;
  reg [LINE_W-1:0] ts_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Lookup, prediction and next address. Both stores are read at next_pc so
  // that the line and table entry for pc are ready in the following cycle.
  always @* begin
    flush = ce & retire_valid & retire_mispredict;
    redirect = retire_taken ? retire_target : retire_pc + `INSTR_BYTES;
    advance = ce & core_ready & ~flush;
    hit = ts_rd_valid && (ln_tag == ts_tag(pc));
    buf_hit = buf_valid && (buf_base == chunk_of(pc));
    instr = buf_data[{pc[`CHUNK_LSB-1:2], 5'h00} +: 32];
    cls = instr[`CLS_MSB:`CLS_LSB];
    disp = {{16{instr[`DISP_MSB]}}, instr[`DISP_MSB:0]};
    fall = pc + `INSTR_BYTES;
    btt_hit = btt_rd_valid && (bt_tag == btt_tag(pc));
    taken = 1'b0;
    target = fall + disp;
    push = 1'b0;
    pop = 1'b0;
    case (cls)
      `CLS_COND: begin
        taken = btt_hit ? bt_taken : disp[31];
        target = btt_hit ? bt_target : fall + disp;
      end
      `CLS_JUMP: taken = 1'b1;
      `CLS_CALL: begin
        taken = 1'b1;
        push = 1'b1;
      end
      `CLS_RET: begin
        taken = (ras_cnt != 0);
        target = ras[ras_top];
        pop = (ras_cnt != 0);
      end
      `CLS_INDIRECT: begin
        taken = btt_hit & bt_taken;
        target = bt_target;
      end
      default: taken = 1'b0; // Far transfers and plain code fall through.
    endcase
    pred_next = taken ? target : fall;
    do_deliver = advance && state == ST_RUN && hit && bld_cnt == 2'h0;
    do_close = advance && state == ST_RUN && hit && bld_cnt != 2'h0;
    do_decode = advance && state == ST_RUN && !hit && buf_hit && cls != `CLS_COMPLEX;
    do_complex = advance && state == ST_RUN && !hit && buf_hit && cls == `CLS_COMPLEX;
    do_fetch = advance && state == ST_RUN && !hit && !buf_hit;
    uc_done = advance && state == ST_UCODE && uc_step == uc_last;
    push = push & do_decode;
    pop = pop & do_decode;
    // Partial lines are closed before a hit or a microcode flow takes over.
    ts_we = do_close | (do_complex & bld_cnt != 2'h0) | (do_decode & bld_cnt == 2'h2);
    if (do_decode) begin
      ts_wdata = {ts_tag(bld_start), pred_next, 2'h3, pc, instr, bld_u1, bld_u0};
    end else begin
      ts_wdata = {ts_tag(bld_start), pc, bld_cnt, {`UOP_W{1'b0}}, bld_u1, bld_u0};
    end
    if (flush) begin
      next_pc = redirect;
    end else if (do_deliver) begin
      next_pc = ln_next;
    end else if (do_decode) begin
      next_pc = pred_next;
    end else if (uc_done) begin
      next_pc = fall;
    end else begin
      next_pc = pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The trace store: 4096 lines of three slots.
  line_memory #(.WIDTH(LINE_W), .ADDR_W(TRACE_IDX_W)) trace_store (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(ts_we),
    .wr_addr(ts_index(bld_start)),
    .wr_data(ts_wdata),
    .rd_addr(ts_index(next_pc)),
    .rd_valid(ts_rd_valid),
    .rd_data(ts_rd_data)
  );

  // Retired branches refresh the table with their real outcome.
  line_memory #(.WIDTH(BTT_W), .ADDR_W(BTT_IDX_W)) branch_target_table (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(retire_valid),
    .wr_addr(btt_index(retire_pc)),
    .wr_data({btt_tag(retire_pc), retire_target, retire_taken}),
    .rd_addr(btt_index(next_pc)),
    .rd_valid(btt_rd_valid),
    .rd_data(btt_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, streaming buffer, trace builder and delivery registers.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      pc <= RESET_PC;
      buf_valid <= 1'b0;
      buf_base <= 32'h0000_0000;
      buf_data <= {`CHUNK_BITS{1'b0}};
      bld_cnt <= 2'h0;
      bld_start <= 32'h0000_0000;
      bld_u0 <= {`UOP_W{1'b0}};
      bld_u1 <= {`UOP_W{1'b0}};
      uc_step <= 3'h0;
      uc_last <= 3'h0;
      uc_op <= 8'h00;
      uop_valid <= 3'h0;
      uop_word0 <= {`UOP_W{1'b0}};
      uop_word1 <= {`UOP_W{1'b0}};
      uop_word2 <= {`UOP_W{1'b0}};
      uop_source <= `SRC_NONE;
      fetch_req <= 1'b0;
      fetch_addr <= 32'h0000_0000;
    end else if (ce) begin
      pc <= next_pc;
      // A chunk in flight is still accepted after a redirect; it is good data.
      if (state == ST_FETCH && fetch_valid) begin
        buf_valid <= 1'b1;
        buf_base <= fetch_addr;
        buf_data <= fetch_data;
        fetch_req <= 1'b0;
        state <= ST_RUN;
      end
      if (flush) begin
        bld_cnt <= 2'h0;
        uop_valid <= 3'h0;
        uop_source <= `SRC_NONE;
        if (state == ST_UCODE) begin
          state <= ST_RUN;
        end
      end else if (core_ready) begin
        uop_valid <= 3'h0;
        uop_source <= `SRC_NONE;
        if (do_deliver) begin
          uop_valid <= cnt_mask(ln_cnt);
          uop_word0 <= ts_rd_data[0 +: `UOP_W];
          uop_word1 <= ts_rd_data[`UOP_W +: `UOP_W];
          uop_word2 <= ts_rd_data[2*`UOP_W +: `UOP_W];
          uop_source <= `SRC_TRACE;
        end
        if (do_close) begin
          bld_cnt <= 2'h0;
        end
        if (do_decode) begin
          uop_valid <= 3'h1;
          uop_word0 <= {pc, instr};
          uop_source <= `SRC_DECODE;
          case (bld_cnt)
            2'h0: begin
              bld_start <= pc;
              bld_u0 <= {pc, instr};
              bld_cnt <= 2'h1;
            end
            2'h1: begin
              bld_u1 <= {pc, instr};
              bld_cnt <= 2'h2;
            end
            default: bld_cnt <= 2'h0;
          endcase
        end
        if (do_complex) begin
          bld_cnt <= 2'h0;
          uc_step <= 3'h0;
          uc_last <= instr[`UC_LEN_MSB:`UC_LEN_LSB];
          uc_op <= instr[`UC_OP_MSB:`UC_OP_LSB];
          state <= ST_UCODE;
        end
        if (advance && state == ST_UCODE) begin
          uop_valid <= 3'h1;
          uop_word0 <= {pc, ucode_rom(uc_op, uc_step)};
          uop_source <= `SRC_UCODE;
          uc_step <= uc_step + 3'h1;
          if (uc_done) begin
            state <= ST_RUN;
          end
        end
        if (do_fetch) begin
          fetch_req <= 1'b1;
          fetch_addr <= chunk_of(pc);
          state <= ST_FETCH;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack as a ring: overflow overwrites the oldest entry. It is not
  // repaired on a misprediction, so deep wrong paths can cost a return.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ras_top <= {`RAS_PTR_W{1'b0}};
      ras_cnt <= {(`RAS_PTR_W+1){1'b0}};
      for (i = 0; i < `RAS_DEPTH; i = i + 1) begin
        ras[i] <= 32'h0000_0000;
      end
    end else if (ce) begin
      if (push) begin
        ras[ras_top + 1'b1] <= fall;
        ras_top <= ras_top + 1'b1;
        if (ras_cnt != `RAS_DEPTH) begin
          ras_cnt <= ras_cnt + 1'b1;
        end
      end else if (pop) begin
        ras_top <= ras_top - 1'b1;
        ras_cnt <= ras_cnt - 1'b1;
      end
    end
  end

endmodule

// ---- tb/frontend_checker.sv ----
`include "frontend_defines.vh"

// Watches the front end's ports only; delivery, stall, fetch and flush behaviour.
module frontend_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic core_ready,
  input wire logic [2:0] uop_valid,
  input wire logic [`UOP_W-1:0] uop_word0,
  input wire logic [`UOP_W-1:0] uop_word1,
  input wire logic [`UOP_W-1:0] uop_word2,
  input wire logic [1:0] uop_source,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [`CHUNK_BITS-1:0] fetch_data,
  input wire logic retire_valid,
  input wire logic [31:0] retire_pc,
  input wire logic [31:0] retire_target,
  input wire logic retire_taken,
  input wire logic retire_mispredict
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // A flush is only honoured on an enabled edge, so both sequences need ce.
  sequence flush_seen;
    ce && retire_valid && retire_mispredict;
  endsequence
  sequence fetch_answered;
    ce && fetch_req && fetch_valid;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Each assertion ties an output to its cause with the figure from the hand-over.
  a_slot_mask_legal: assert property (uop_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("slot mask is not a packed group");
  a_single_decode: assert property (uop_valid != 3'h0 && uop_source inside {2'h2, 2'h3}
    |-> uop_valid == 3'h1) else $error("decoder or microcode gave more than one uop");
  a_group_source: assert property (uop_valid != 3'h0 |-> uop_source != 2'h0)
    else $error("valid group without a source");
  a_stall_holds: assert property (ce && uop_valid != 3'h0 && !core_ready
    && !(retire_valid && retire_mispredict)
    |=> $stable(uop_valid) && $stable(uop_word0) && $stable(uop_word2))
    else $error("group changed while the core stalled");
  a_freeze_holds: assert property (!ce |=> $stable(fetch_req) && $stable(fetch_addr)
    && $stable(uop_valid)) else $error("state moved with clock enable low");
  a_fetch_holds: assert property (fetch_req && !(ce && fetch_valid)
    |=> fetch_req && $stable(fetch_addr)) else $error("fetch request dropped or moved");
  a_chunk_aligned: assert property (fetch_req |-> fetch_addr[4:0] == 5'h00)
    else $error("fetch address not on a chunk boundary");
  a_fetch_released: assert property (fetch_answered |=> !fetch_req)
    else $error("fetch request stayed up after its answer");
  a_flush_clears: assert property (flush_seen |=> uop_valid == 3'h0)
    else $error("wrong-path group survived a flush");
  a_flush_restarts: assert property (flush_seen ##0 !fetch_req
    |-> ##[1:6] (uop_valid != 3'h0 || fetch_req)) else $error("no restart after flush");
  a_reset_quiet: assert property (disable iff (1'b0) rst
    |-> uop_valid == 3'h0 && !fetch_req && uop_source == 2'h0)
    else $error("outputs active during reset");
endmodule

bind instruction_frontend_predictor frontend_checker chk (.clk(clk), .rst(rst), .ce(ce),
  .core_ready(core_ready), .uop_valid(uop_valid), .uop_word0(uop_word0),
  .uop_word1(uop_word1), .uop_word2(uop_word2), .uop_source(uop_source),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
  .fetch_data(fetch_data), .retire_valid(retire_valid), .retire_pc(retire_pc),
  .retire_target(retire_target), .retire_taken(retire_taken),
  .retire_mispredict(retire_mispredict));

// ---- tb/code_memory_model.sv ----
// Memory hierarchy seen by the fetcher: one chunk per request after lat idle cycles.
module code_memory_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [255:0] fetch_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] image [0:63];
  int lat = 1;
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // The pulse waits for an enabled edge so a frozen front end cannot lose it.
  // Outside the pulse the data lines show the inverse of the last chunk, so
  // stale words can never pass for a fresh answer.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'h0;
      fetch_data <= {8{32'h5A5A_A5A5}};
      cnt <= 0;
    end else if (fetch_valid) begin
      if (ce) begin
        fetch_valid <= 1'h0;
        fetch_data <= ~fetch_data;
      end
    end else if (fetch_req && cnt >= lat) begin
      fetch_valid <= 1'h1;
      cnt <= 0;
      for (int k = 0; k < 8; k++) begin
        fetch_data[32*k +: 32] <= image[{fetch_addr[7:5], k[2:0]}];
      end
    end else begin
      cnt <= fetch_req ? cnt + 1 : 0;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`include "frontend_defines.vh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
  typedef struct {logic [31:0] pc; logic [31:0] pay; logic ucode;} row_t;
  // One pass of the program in delivery order: call, return, forward and backward
  // conditionals, a far transfer, and 0x0C expanding into three microcode steps.
  row_t rows [10] = '{'{32'h0000_0000, 32'h0000_00A0, 1'h0},
    '{32'h0000_0004, 32'h6000_0038, 1'h0}, '{32'h0000_0040, 32'h0000_00A1, 1'h0},
    '{32'h0000_0044, 32'h8000_0000, 1'h0}, '{32'h0000_0008, 32'h2000_0008, 1'h0},
    '{32'h0000_000C, 32'hEC5A_0000, 1'h1}, '{32'h0000_000C, 32'hEC5A_0001, 1'h1},
    '{32'h0000_000C, 32'hEC5A_0002, 1'h1}, '{32'h0000_0010, 32'hC000_0100, 1'h0},
    '{32'h0000_0014, 32'h2000_FFE8, 1'h0}};
  logic clk = 1'h0, rst = 1'h0, ce = 1'h1, core_ready = 1'h1, saw_full = 1'h0;
  logic retire_valid = 1'h0, retire_taken = 1'h0, retire_mispredict = 1'h0;
  logic [31:0] retire_pc = 32'h0000_0000, retire_target = 32'h0000_0000;
  wire [2:0] uop_valid;
  wire [`UOP_W-1:0] uop_word0, uop_word1, uop_word2;
  wire [1:0] uop_source;
  wire fetch_req, fetch_valid;
  wire [31:0] fetch_addr;
  wire [`CHUNK_BITS-1:0] fetch_data;
  int err_total = 0, n_tests = 0, k;
  logic [65:0] q [$];
  logic [63:0] held;

  always #2.5 clk = ~clk;

  instruction_frontend_predictor dut (.clk(clk), .rst(rst), .ce(ce), .core_ready(core_ready),
    .uop_valid(uop_valid), .uop_word0(uop_word0), .uop_word1(uop_word1),
    .uop_word2(uop_word2), .uop_source(uop_source), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .retire_valid(retire_valid), .retire_pc(retire_pc), .retire_target(retire_target),
    .retire_taken(retire_taken), .retire_mispredict(retire_mispredict));
  code_memory_model mem (.clk(clk), .rst(rst), .ce(ce), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data));

  ////////////////////////////////////////////////////////////////////////////
  // Records every accepted micro-operation with its source, oldest slot first.
  always @(posedge clk) begin
    if (!rst && ce && core_ready) begin
      if (uop_valid[0] === 1'h1) q.push_back({uop_source, uop_word0});
      if (uop_valid[1] === 1'h1) q.push_back({uop_source, uop_word1});
      if (uop_valid[2] === 1'h1) q.push_back({uop_source, uop_word2});
      if (uop_valid === 3'h7 && uop_source === 2'h1) saw_full <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bounded wait for n accepted uops; stall mode drops core_ready every 7th cycle.
  task automatic wait_uops(input int n, input logic stall);
    int c;
    c = 0;
    while (q.size() < n && c < 5000) begin
      @(negedge clk);
      core_ready = !(stall && c % 7 == 3);
      c++;
    end
    `CHECK("uop count", 1'h1, q.size() >= n)
  endtask

  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    // A real rising reset edge before the first clock, so no output starts unknown.
    #1 rst = 1'h1;
    for (k = 0; k < 64; k++) mem.image[k] = 32'h0000_0000;
    mem.image[3] = 32'hE85A_0000;
    foreach (rows[i]) begin
      if (!rows[i].ucode) mem.image[rows[i].pc[7:2]] = rows[i].pay;
    end
    repeat (6) @(posedge clk);
    `CHECK("reset uop_valid", 3'h0, uop_valid)
    `CHECK("reset fetch_req", 1'h0, fetch_req)
    @(negedge clk);
    rst = 1'h0;
    $display("test reset done");
    // Slow memory and core stalls; three passes cover decode, microcode and replay.
    mem.lat = 4;
    wait_uops(30, 1'h1);
    for (k = 0; k < 30 && k < q.size(); k++) begin
      `CHECK("uop pc", rows[k % 10].pc, q[k][63:32])
      `CHECK("uop payload", rows[k % 10].pay, q[k][31:0])
      if (rows[k % 10].ucode) `CHECK("uop source", 2'h3, q[k][65:64])
    end
    `CHECK("full trace group", 1'h1, saw_full)
    $display("test program rows done");
    @(negedge clk);
    ce = 1'h0;
    core_ready = 1'h1;
    held = uop_word0;
    k = q.size();
    repeat (5) @(negedge clk);
    `CHECK("frozen word0", held, uop_word0)
    `CHECK("frozen queue", k, q.size())
    $display("test freeze done");
    // Prompt memory; a stalled core sees the flush so no group is taken at that edge.
    mem.lat = 0;
    @(negedge clk);
    ce = 1'h1;
    core_ready = 1'h0;
    // One resolved branch, reported after it completed.
    retire_valid = 1'h1;
    retire_pc = 32'h0000_0008;
    retire_target = 32'h0000_0014;
    retire_taken = 1'h1;
    retire_mispredict = 1'h1;
    @(negedge clk);
    retire_valid = 1'h0;
    retire_mispredict = 1'h0;
    `CHECK("flushed uop_valid", 3'h0, uop_valid)
    q.delete();
    wait_uops(2, 1'h0);
    `CHECK("restart pc", 32'h0000_0014, q[0][63:32])
    `CHECK("after restart pc", 32'h0000_0000, q[1][63:32])
    $display("test mispredict done");
    report_and_stop();
  end

  // The run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("mismatch watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
